// ==== hdl/rap_panel.sv ====
/*
  rap_panel: front-panel adjustment controller of a twisted-pair video
  receiver: select/up/down buttons, three colour leds, two settings.
  assumes: buttons synchronous and active high; power-on reset on rst.
*/
`timescale 1ns/1ps
`default_nettype none
module rap_panel
  import rap_pkg::*;
#(
  parameter int unsigned HOLD_N    = HOLD_CYC,     // long hold cycles
  parameter int unsigned TIMEOUT_N = TIMEOUT_CYC,  // one minute in cycles
  parameter int unsigned BLINK_N   = BLINK_CYC,    // limit blink length
  parameter int unsigned HALF_N    = BLINK_HALF_CYC // brightness blink half
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             sel_btn,
  input  wire logic             up_btn,
  input  wire logic             down_btn,
  output logic [2:0]            led,
  output logic [SET_W-1:0]      high_freq_comp,
  output logic [SET_W-1:0]      brightness,
  output logic [2:0]            mode
);

  // --------------------------------------------------------------------
  // button conditioning
  // --------------------------------------------------------------------
  rap_btn_if sel_ev ();   // select events
  rap_btn_if up_ev  ();   // up events
  rap_btn_if dn_ev  ();   // down events

  rap_btn #(.HOLD_N(HOLD_N)) u_sel (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (sel_btn),
    .ev      (sel_ev)
  );
  rap_btn #(.HOLD_N(HOLD_N)) u_up (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (up_btn),
    .ev      (up_ev)
  );
  rap_btn #(.HOLD_N(HOLD_N)) u_dn (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (down_btn),
    .ev      (dn_ev)
  );

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    rap_mode_t        mode;      // panel mode
    logic [SET_W-1:0] comp;      // compensation setting
    logic [SET_W-1:0] brt;       // brightness setting
    logic [CNT_W-1:0] tmo;       // inactivity timer
    logic [CNT_W-1:0] blk;       // limit blink remaining
    logic [CNT_W-1:0] ph;        // brightness blink phase counter
    logic             ph_on;     // brightness blink phase
    logic             sel_pend;  // select pressed, waiting for release
    logic             hold_done; // this select press was a long hold
    logic [2:0]       led;       // registered led drive
  } rap_panel_st_t;

  rap_panel_st_t st_r, st_nxt;

  logic any_press;   // any button press event this cycle
  logic both;        // up and down together
  logic inc;         // single up press
  logic dec;         // single down press
  logic hit_limit;   // press ran into a limit

  // --------------------------------------------------------------------
  // event decode
  // --------------------------------------------------------------------
  // both counts when one edge arrives while the other button is down,
  // so the pair need not land in the same cycle
  always_comb begin
    any_press = sel_ev.press | up_ev.press | dn_ev.press;
    both      = (up_ev.press & dn_ev.level) | (dn_ev.press & up_ev.level);
    inc       = up_ev.press & !dn_ev.level;
    dec       = dn_ev.press & !up_ev.level;
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    hit_limit = 1'b0;

    // select acts on release so a long hold is not also a short press
    if (sel_ev.press) begin
      st_nxt.sel_pend  = 1'b1;
      st_nxt.hold_done = 1'b0;
    end

    case (st_r.mode)
      RAP_IDLE: begin
        if (st_r.sel_pend && !sel_ev.level) begin
          st_nxt.mode     = RAP_ADJ;
          st_nxt.sel_pend = 1'b0;
        end
      end
      RAP_ADJ: begin
        if (sel_ev.hold) begin
          st_nxt.mode      = RAP_BRT;
          st_nxt.hold_done = 1'b1;
        end else if (st_r.sel_pend && !sel_ev.level) begin
          st_nxt.sel_pend = 1'b0;
          if (!st_r.hold_done) begin
            st_nxt.mode = RAP_IDLE;
          end
        end else if (both) begin
          st_nxt.comp = COMP_ZERO;
        end else if (inc) begin
          if (st_r.comp == COMP_MAX) begin
            hit_limit = 1'b1;
          end else begin
            st_nxt.comp = st_r.comp + SET_STEP;
          end
        end else if (dec) begin
          if (st_r.comp == COMP_MIN) begin
            hit_limit = 1'b1;
          end else begin
            st_nxt.comp = st_r.comp - SET_STEP;
          end
        end
      end
      RAP_BRT: begin
        if (st_r.sel_pend && !sel_ev.level) begin
          st_nxt.sel_pend = 1'b0;
          // release of the hold that brought us here is not a press
          if (!st_r.hold_done) begin
            st_nxt.mode = RAP_ADJ;
          end
          st_nxt.hold_done = 1'b0;
        end else if (both) begin
          st_nxt.brt = BRT_DEF;
        end else if (inc) begin
          if (st_r.brt == BRT_MAX) begin
            hit_limit = 1'b1;
          end else begin
            st_nxt.brt = st_r.brt + SET_STEP;
          end
        end else if (dec) begin
          if (st_r.brt == BRT_MIN) begin
            hit_limit = 1'b1;
          end else begin
            st_nxt.brt = st_r.brt - SET_STEP;
          end
        end
      end
      default: begin
        st_nxt.mode = RAP_IDLE;
      end
    endcase

    // inactivity timeout, restarted by any press
    if (st_r.mode == RAP_IDLE || any_press) begin
      st_nxt.tmo = '0;
    end else if (st_r.tmo >= CNT_W'(TIMEOUT_N - 1)) begin
      st_nxt.tmo       = '0;
      st_nxt.mode      = RAP_IDLE;
      st_nxt.sel_pend  = 1'b0;
      st_nxt.hold_done = 1'b0;
    end else begin
      st_nxt.tmo = st_r.tmo + 1'b1;
    end

    // one limit blink: leds dark for BLINK_N cycles
    if (hit_limit) begin
      st_nxt.blk = CNT_W'(BLINK_N);
    end else if (st_r.blk != '0) begin
      st_nxt.blk = st_r.blk - 1'b1;
    end

    // free-running phase for brightness-mode blinking
    if (st_r.ph >= CNT_W'(HALF_N - 1)) begin
      st_nxt.ph    = '0;
      st_nxt.ph_on = !st_r.ph_on;
    end else begin
      st_nxt.ph = st_r.ph + 1'b1;
    end

    // led drive from the mode just chosen
    case (st_nxt.mode)
      RAP_ADJ:  st_nxt.led = LED_ALL;
      RAP_BRT:  st_nxt.led = st_nxt.ph_on ? LED_GB : LED_OFF;
      default:  st_nxt.led = LED_OFF;
    endcase
    if (st_nxt.blk != '0) begin
      st_nxt.led = LED_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r       <= '0;
      st_r.mode  <= RAP_IDLE;
      st_r.comp  <= COMP_ZERO;
      st_r.brt   <= BRT_DEF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // outputs, all from flip-flops
  // --------------------------------------------------------------------
  assign led            = st_r.led;
  assign high_freq_comp = st_r.comp;
  assign brightness     = st_r.brt;
  assign mode           = st_r.mode;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  // select release in idle is the one-step way into adjustment
  sequence s_idle_sel_release;
    st_r.mode == RAP_IDLE && st_r.sel_pend && !sel_ev.level;
  endsequence

  // short select release in adjustment, not eaten by a hold or timeout
  sequence s_adj_sel_release;
    st_r.mode == RAP_ADJ && st_r.sel_pend && !sel_ev.level && !st_r.hold_done
      && !sel_ev.hold && st_r.tmo < CNT_W'(TIMEOUT_N - 1);
  endsequence

  // a long hold lands in brightness and stays out of idle one cycle more
  sequence s_brt_settle;
    st_r.mode == RAP_BRT ##1 st_r.mode != RAP_IDLE;
  endsequence

  AST_IDLE_ENTER: assert property (@(posedge ref_clk) disable iff (rst)
    s_idle_sel_release |=> st_r.mode == RAP_ADJ)
    else $error("select release in idle did not enter adjustment");
  AST_ADJ_LEDS: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_ADJ && st_r.blk == '0) |-> led == LED_ALL)
    else $error("adjustment leds not solid");
  AST_COMP_UP: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_ADJ && inc && !sel_ev.hold && !st_r.sel_pend
      && st_r.tmo < CNT_W'(TIMEOUT_N - 1) && st_r.comp != COMP_MAX)
      |=> high_freq_comp == $past(high_freq_comp) + SET_STEP)
    else $error("up press did not step compensation");
  AST_COMP_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_ADJ && dec && !sel_ev.hold && !st_r.sel_pend
      && st_r.comp != COMP_MIN)
      |=> high_freq_comp == $past(high_freq_comp) - SET_STEP)
    else $error("down press did not step compensation");
  AST_LIMIT_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    hit_limit |=> (st_r.blk != '0) && (led == LED_OFF))
    else $error("limit press did not blink");
  // a press at a limit must leave both settings where they were
  AST_LIMIT_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    hit_limit |=> high_freq_comp == $past(high_freq_comp)
      && brightness == $past(brightness))
    else $error("limit press changed a setting");
  AST_COMP_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_ADJ && both && !sel_ev.hold && !st_r.sel_pend)
      |=> high_freq_comp == COMP_ZERO)
    else $error("both buttons did not zero compensation");
  AST_SEL_EXIT: assert property (@(posedge ref_clk) disable iff (rst)
    s_adj_sel_release |=> st_r.mode == RAP_IDLE)
    else $error("select in adjustment did not return to idle");
  AST_TIMEOUT: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode != RAP_IDLE && st_r.tmo >= CNT_W'(TIMEOUT_N - 1) && !any_press)
      |=> st_r.mode == RAP_IDLE)
    else $error("timeout did not return to idle");
  // two cycles of margin: the settle step must not meet the timeout
  AST_HOLD_BRT: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_ADJ && sel_ev.hold && st_r.tmo < CNT_W'(TIMEOUT_N - 2))
      |=> s_brt_settle)
    else $error("long hold did not enter brightness");
  // red stays dark, green and blue follow the blink phase together
  AST_BRT_LEDS: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_BRT && st_r.blk == '0)
      |-> !led[LED_R] && (led[LED_G] == led[LED_B]) && (led[LED_G] == st_r.ph_on))
    else $error("brightness leds not blinking green and blue");
  AST_BRT_UP: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_BRT && inc && !st_r.sel_pend && st_r.brt != BRT_MAX)
      |=> brightness == $past(brightness) + SET_STEP)
    else $error("up press did not step brightness");
  AST_BRT_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_BRT && dec && !st_r.sel_pend && st_r.brt != BRT_MIN)
      |=> brightness == $past(brightness) - SET_STEP)
    else $error("down press did not step brightness");
  AST_BRT_DEF: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_BRT && both && !st_r.sel_pend)
      |=> brightness == BRT_DEF)
    else $error("both buttons did not restore brightness");
  AST_BRT_RET: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == RAP_BRT && st_r.sel_pend && !sel_ev.level && !st_r.hold_done
      && st_r.tmo < CNT_W'(TIMEOUT_N - 1))
      |=> st_r.mode == RAP_ADJ)
    else $error("select in brightness did not return");
  AST_TMO_RESTART: assert property (@(posedge ref_clk) disable iff (rst)
    any_press |=> st_r.tmo == '0)
    else $error("press did not restart timeout");

endmodule : rap_panel
`default_nettype wire

// ==== hdl/rap_pkg.sv ====
/*
  rap_pkg: constants, types and timing figures shared by the receiver
  adjustment panel modules.
  assumes: a 25 MHz system clock; buttons arrive already synchronous.
*/
package rap_pkg;

  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25000000;  // ref_clk rate
  localparam int unsigned DEBOUNCE_US   = 10;        // button settle time
  localparam int unsigned DEBOUNCE_CYC  = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int unsigned HOLD_MS       = 3000;      // long select hold
  localparam int unsigned HOLD_CYC      = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned TIMEOUT_MS    = 60000;     // idle-return timeout
  localparam int unsigned TIMEOUT_CYC   = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned BLINK_MS      = 200;       // one limit blink
  localparam int unsigned BLINK_CYC     = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned BLINK_HALF_MS = 250;       // brightness blink half
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

  localparam int CNT_W = 32;                         // timer width

  // --------------------------------------------------------------------
  // settings
  // --------------------------------------------------------------------
  localparam int SET_W = 6;                          // setting width
  localparam logic [5:0] COMP_MIN   = 6'h00;         // compensation floor
  localparam logic [5:0] COMP_MAX   = 6'h3F;         // compensation ceiling
  localparam logic [5:0] COMP_ZERO  = 6'h00;         // both-button value
  localparam logic [5:0] BRT_MIN    = 6'h00;         // brightness floor
  localparam logic [5:0] BRT_MAX    = 6'h1F;         // brightness ceiling
  localparam logic [5:0] BRT_DEF    = 6'h10;         // brightness default
  localparam logic [5:0] SET_STEP   = 6'h01;         // one adjustment step

  // led vector positions
  localparam int LED_R = 0;
  localparam int LED_G = 1;
  localparam int LED_B = 2;
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_ALL = 3'h7;
  localparam logic [2:0] LED_GB  = 3'h6;

  // --------------------------------------------------------------------
  // panel modes, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    RAP_IDLE = 3'h1,   // all leds off
    RAP_ADJ  = 3'h2,   // compensation adjust, leds solid
    RAP_BRT  = 3'h4    // brightness adjust, green/blue blink
  } rap_mode_t;

endpackage : rap_pkg

// ==== hdl/rap_btn_if.sv ====
/*
  rap_btn_if: carries one cleaned button's events from a conditioner to
  the panel controller.
  assumes: single clock domain, events are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
interface rap_btn_if;
  logic level;   // debounced button level
  logic press;   // one-cycle pulse on press edge
  logic hold;    // one-cycle pulse when hold time is reached
  modport src (output level, output press, output hold);
  modport dst (input level, input press, input hold);
endinterface : rap_btn_if
`default_nettype wire

// ==== hdl/rap_btn.sv ====
/*
  rap_btn: debounce one push button, emit press and long-hold pulses.
  assumes: raw input synchronous to ref_clk, active high when pressed.
*/
`timescale 1ns/1ps
`default_nettype none
module rap_btn
  import rap_pkg::*;
#(
  parameter int unsigned HOLD_N = HOLD_CYC   // cycles for a long hold
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic raw,
  rap_btn_if.src    ev
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic             level;   // accepted level
    logic [CNT_W-1:0] deb;     // settle counter
    logic [CNT_W-1:0] held;    // time held
    logic             press;
    logic             hold;
  } rap_btn_st_t;

  rap_btn_st_t st_r, st_nxt;

  // debounce: raw must differ from level for DEBOUNCE_CYC in a row
  always_comb begin
    st_nxt       = st_r;
    st_nxt.press = 1'b0;
    st_nxt.hold  = 1'b0;
    if (raw != st_r.level) begin
      if (st_r.deb >= CNT_W'(DEBOUNCE_CYC - 1)) begin
        st_nxt.level = raw;
        st_nxt.deb   = '0;
        st_nxt.held  = '0;
        st_nxt.press = raw;
      end else begin
        st_nxt.deb = st_r.deb + 1'b1;
      end
    end else begin
      st_nxt.deb = '0;
    end
    // hold timer only runs while accepted level is pressed
    if (st_r.level && (raw == st_r.level)) begin
      if (st_r.held < CNT_W'(HOLD_N)) begin
        st_nxt.held = st_r.held + 1'b1;
        st_nxt.hold = (st_r.held == CNT_W'(HOLD_N - 1));
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev.level = st_r.level;
  assign ev.press = st_r.press;
  assign ev.hold  = st_r.hold;

  AST_ONE_PRESS: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.press |=> !st_r.press)
    else $error("press pulse longer than one cycle");

endmodule : rap_btn
`default_nettype wire

// ==== sim/rap_keys.sv ====
/*
  rap_keys: model of the front-panel buttons and the leds they light.
  assumes: one ref_clk; buttons change on its falling edge only.
*/
`timescale 1ns/1ps
`default_nettype none
module rap_keys (
  input  wire logic       ref_clk,   // panel clock
  input  wire logic [2:0] led,       // leds watched by the operator
  output var  logic       sel_btn,   // select, high = pressed
  output var  logic       up_btn,    // up, high = pressed
  output var  logic       down_btn   // down, high = pressed
);
  int dark_cnt;  // cycles with all leds dark during the last push

  // --------------------------------------------------------------------
  // buttons rest released from time zero
  // --------------------------------------------------------------------
  initial begin
    sel_btn  = 1'b0;
    up_btn   = 1'b0;
    down_btn = 1'b0;
    dark_cnt = 0;
  end

  // press {down,up,sel} for n cycles, then rest 300 cycles so that the
  // release also clears the 250-cycle settle filter before the next push
  task automatic push(input logic [2:0] keys, input int n);
    dark_cnt = 0;
    @(negedge ref_clk);
    {down_btn, up_btn, sel_btn} = keys;
    repeat (n) begin
      @(negedge ref_clk);
      if (led === 3'h0) dark_cnt++;
    end
    {down_btn, up_btn, sel_btn} = 3'h0;
    repeat (300) begin
      @(negedge ref_clk);
      if (led === 3'h0) dark_cnt++;
    end
  endtask : push
endmodule : rap_keys
`default_nettype wire

// ==== sim/testbench.sv ====
/*
  testbench: self-checking bench of rap_panel with shortened timers.
  assumes: rap_pkg compiled first; rap_keys plays the front panel.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rap_pkg::*;

  // --------------------------------------------------------------------
  // shortened timers, so a run stays near 30k cycles
  // --------------------------------------------------------------------
  localparam int unsigned HOLD_T = 2000;
  localparam int unsigned TMO_T  = 5000;
  localparam int unsigned BLK_T  = 20;
  localparam int unsigned HALF_T = 10;

  logic             ref_clk;          // 25 MHz clock
  logic             rst;              // synchronous reset
  wire logic        sel_btn;          // from the panel model
  wire logic        up_btn;
  wire logic        down_btn;
  logic [2:0]       led;              // design outputs
  logic [SET_W-1:0] high_freq_comp;
  logic [SET_W-1:0] brightness;
  logic [2:0]       mode;
  int               err_total;        // mismatches
  int               samples_checked;  // comparisons
  int               cyc;              // hang guard

  rap_panel #(.HOLD_N(HOLD_T), .TIMEOUT_N(TMO_T), .BLINK_N(BLK_T), .HALF_N(HALF_T)) DUT (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .sel_btn        (sel_btn),
    .up_btn         (up_btn),
    .down_btn       (down_btn),
    .led            (led),
    .high_freq_comp (high_freq_comp),
    .brightness     (brightness),
    .mode           (mode)
  );

  rap_keys u_keys (
    .ref_clk  (ref_clk),
    .led      (led),
    .sel_btn  (sel_btn),
    .up_btn   (up_btn),
    .down_btn (down_btn)
  );

  // --------------------------------------------------------------------
  // clock, reset and hang guard
  // --------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // a stuck mode machine would otherwise run forever
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end

  // --------------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one ordinary press, long enough to pass the settle filter
  task automatic tap(input logic [2:0] keys);
    u_keys.push(keys, 300);
  endtask : tap

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  // reset state, then up in idle must be ignored
  task automatic t_idle();
    chk(led, LED_OFF);
    chk(mode, RAP_IDLE);
    chk(brightness, BRT_DEF);
    tap(3'h2);
    chk(high_freq_comp, COMP_MIN);
    chk(mode, RAP_IDLE);
  endtask : t_idle

  // enter adjust, short glitch refused, steps up and down
  task automatic t_adjust();
    tap(3'h1);
    chk(mode, RAP_ADJ);
    chk(led, LED_ALL);
    u_keys.push(3'h2, 100);
    chk(high_freq_comp, 8'h00);
    repeat (3) tap(3'h2);
    chk(high_freq_comp, 8'h03);
    tap(3'h4);
    chk(high_freq_comp, 8'h02);
    chk(u_keys.dark_cnt, 0);
    tap(3'h6);
    chk(high_freq_comp, COMP_ZERO);
    tap(3'h4);
    chk(high_freq_comp, COMP_MIN);
    chk(u_keys.dark_cnt, BLK_T);
    chk(led, LED_ALL);
  endtask : t_adjust

  // long select into brightness, blink, upper limit, default, walk back out
  task automatic t_bright();
    int n6;
    int n0;
    n6 = 0;
    n0 = 0;
    u_keys.push(3'h1, HOLD_T + 400);
    chk(mode, RAP_BRT);
    repeat (40) begin
      @(negedge ref_clk);
      if (led === LED_GB) n6++;
      else if (led === LED_OFF) n0++;
    end
    chk(n6, 20);
    chk(n0, 20);
    repeat (15) tap(3'h2);
    chk(brightness, BRT_MAX);
    tap(3'h2);
    chk(brightness, BRT_MAX);
    tap(3'h4);
    chk(brightness, 8'h1E);
    tap(3'h6);
    chk(brightness, BRT_DEF);
    chk(high_freq_comp, COMP_MIN);
    tap(3'h1);
    chk(mode, RAP_ADJ);
    chk(led, LED_ALL);
    tap(3'h1);
    chk(mode, RAP_IDLE);
    chk(led, LED_OFF);
  endtask : t_bright

  // a press restarts the timeout; silence then returns to idle
  task automatic t_timeout();
    tap(3'h1);
    repeat (4000) @(negedge ref_clk);
    tap(3'h2);
    repeat (4000) @(negedge ref_clk);
    chk(mode, RAP_ADJ);
    repeat (1000) @(negedge ref_clk);
    chk(mode, RAP_IDLE);
    chk(led, LED_OFF);
  endtask : t_timeout

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    rst             = 1'b1;
    err_total       = 0;
    samples_checked = 0;
    cyc             = 0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_idle();
    t_adjust();
    t_bright();
    t_timeout();
    close_out();
  end
endmodule : testbench
`default_nettype wire
